// ===== ext_pin_irq_pkg.sv
// constants shared by the pin interrupt unit and its helpers
// assumes one 100 MHz clock and a byte-addressed 32-bit register port

package ext_pin_irq_pkg;

   // ==========================================================
   // sizes
   localparam int NUM_PINS   = 8;
   localparam int CFG_SLICE  = 4;
   localparam int CFG_FILT   = 3;

   // ==========================================================
   // byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h01;
   localparam logic [7:0] OFS_NMI_CTRL = 8'h02;
   localparam logic [7:0] OFS_NMI_FLAG = 8'h03;
   localparam logic [7:0] OFS_EVT_EN   = 8'h04;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h08;
   localparam logic [7:0] OFS_IRQ_SET  = 8'h0c;
   localparam logic [7:0] OFS_FLAGS    = 8'h10;
   localparam logic [7:0] OFS_WAKE     = 8'h14;
   localparam logic [7:0] OFS_PIN_CFG  = 8'h18;

   // ==========================================================
   // field positions
   localparam int CTRL_SOFT_RESET_BIT_BIT  = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam int STATUS_SYNC_BIT = 7;
   localparam int NMI_FLAG_BIT    = 0;

   // ==========================================================
   // reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // ==========================================================
   // sense codes
   localparam logic [2:0] SENSE_NONE = 3'h0;
   localparam logic [2:0] SENSE_RISE = 3'h1;
   localparam logic [2:0] SENSE_FALL = 3'h2;
   localparam logic [2:0] SENSE_BOTH = 3'h3;
   localparam logic [2:0] SENSE_HIGH = 3'h4;
   localparam logic [2:0] SENSE_LOW  = 3'h5;

   // ==========================================================
   // timing
   localparam logic [1:0] SYNC_CYCLES = 2'h3;

endpackage

// ===== pin_detect.sv
// one pin: two-stage synchroniser, optional majority filter, sense decode
// assumes the pin is asynchronous to clk_i
`timescale 1ns/10ps

module pin_detect (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // pin and configuration
   input  wire logic       pin_i,
   input  wire logic [2:0] sense_i,
   input  wire logic       filt_on_i,
   // detection
   output logic            hit_o,
   output logic            evt_o
);

   logic       meta_r;
   logic       sync_r;
   logic [1:0] hist_r;
   logic       prev_r;
   logic       hit_prev_r;
   wire  logic maj      = (sync_r & hist_r[0]) | (sync_r & hist_r[1]) | (hist_r[0] & hist_r[1]);
   wire  logic val      = filt_on_i ? maj : sync_r;
   wire  logic rise     = val & ~prev_r;
   wire  logic fall     = ~val & prev_r;
   wire  logic is_edge  = (sense_i == ext_pin_irq_pkg::SENSE_RISE) |
                          (sense_i == ext_pin_irq_pkg::SENSE_FALL) |
                          (sense_i == ext_pin_irq_pkg::SENSE_BOTH);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_r     <= 1'b0;
         sync_r     <= 1'b0;
         hist_r     <= 2'h0;
         prev_r     <= 1'b0;
         hit_prev_r <= 1'b0;
      end else begin
         meta_r     <= pin_i;
         sync_r     <= meta_r;
         hist_r     <= {hist_r[0], sync_r};
         prev_r     <= val;
         hit_prev_r <= hit_o;
      end
   end

   // reserved codes 6 and 7 detect nothing
   always_comb begin
      unique case (sense_i)
         ext_pin_irq_pkg::SENSE_RISE: hit_o = rise;
         ext_pin_irq_pkg::SENSE_FALL: hit_o = fall;
         ext_pin_irq_pkg::SENSE_BOTH: hit_o = rise | fall;
         ext_pin_irq_pkg::SENSE_HIGH: hit_o = val;
         ext_pin_irq_pkg::SENSE_LOW:  hit_o = ~val;
         default:                     hit_o = 1'b0;
      endcase
   end

   // a level match gives one event at its onset only
   assign evt_o = is_edge ? hit_o : (hit_o & ~hit_prev_r);

   property p_none_quiet;
      @(posedge clk_i) disable iff (srst_i)
      (sense_i == ext_pin_irq_pkg::SENSE_NONE) |-> !hit_o;
   endproperty
   a_none_quiet: assert property (p_none_quiet) else $error("hit with sense none");

   property p_majority;
      @(posedge clk_i) disable iff (srst_i)
      (filt_on_i && sync_r && hist_r[0]) |=> prev_r;
   endproperty
   a_majority: assert property (p_majority) else $error("filter lost majority");

endmodule

// ===== sync_track.sv
// busy tracker standing in for the cross-domain write handshake
// assumes start_i is a one-cycle pulse accepted only while idle
`timescale 1ns/10ps

module sync_track (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // handshake
   input  wire logic start_i,
   output logic      busy_o,
   output logic      done_o
);

   logic       busy_r;
   logic [1:0] cnt_r;
   wire  logic last = busy_r & (cnt_r == ext_pin_irq_pkg::SYNC_CYCLES);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         busy_r <= 1'b0;
         cnt_r  <= 2'h0;
      end else if (start_i) begin
         busy_r <= 1'b1;
         cnt_r  <= 2'h1;
      end else if (last) begin
         busy_r <= 1'b0;
         cnt_r  <= 2'h0;
      end else if (busy_r) begin
         cnt_r  <= cnt_r + 2'h1;
      end
   end

   assign busy_o = busy_r;
   assign done_o = last;

endmodule

// ===== ext_pin_irq_unit.sv
// external pin interrupt unit: registers, flags, events, wake and sync control
// assumes a byte-addressed 32-bit register port with byte enables, one clock
`timescale 1ns/10ps

module ext_pin_irq_unit (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // register port
   input  wire logic        req_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [3:0]  be_i,
   input  wire logic [31:0] wdata_i,
   output logic             ready_o,
   output logic             rvalid_o,
   output logic [31:0]      rdata_o,
   // system
   input  wire logic        access_guard_i,
   input  wire logic        sleep_i,
   // pins
   input  wire logic [7:0]  ext_irq_pin_i,
   input  wire logic        nmi_pin_i,
   // requests and events
   output logic             irq_o,
   output logic             nmi_irq_o,
   output logic [7:0]       evt_o,
   output logic             wake_o
);

   // ==========================================================
   // state
   logic        soft_reset_bit_r;
   logic        enable_r;
   logic        enable_eff_r;
   logic [3:0]  nmi_ctrl_r;
   logic        nmi_flag_r;
   logic [7:0]  evt_en_r;
   logic [7:0]  irq_en_r;
   logic [7:0]  flags_r;
   logic [7:0]  wake_en_r;
   logic [31:0] cfg_r;
   logic [7:0]  hit_evt_r;
   logic        wake_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [7:0]  hit;
   logic [7:0]  pin_evt;
   logic        nmi_hit;
   logic        sync_busy;
   logic        sync_done;

   // ==========================================================
   // decode
   wire logic [5:0] word   = addr_i[7:2];
   wire logic sel_ctrl     = word == ext_pin_irq_pkg::OFS_CTRL[7:2];
   wire logic sel_evt      = word == ext_pin_irq_pkg::OFS_EVT_EN[7:2];
   wire logic sel_clr      = word == ext_pin_irq_pkg::OFS_IRQ_CLR[7:2];
   wire logic sel_set      = word == ext_pin_irq_pkg::OFS_IRQ_SET[7:2];
   wire logic sel_flags    = word == ext_pin_irq_pkg::OFS_FLAGS[7:2];
   wire logic sel_wake     = word == ext_pin_irq_pkg::OFS_WAKE[7:2];
   wire logic sel_cfg      = word == ext_pin_irq_pkg::OFS_PIN_CFG[7:2];
   // status, nmi control and nmi flag share the control word on lanes 1..3
   wire logic ctrl_touch   = req_i & wr_i & sel_ctrl & be_i[0];
   // only the control byte can hold the bus; status and the rest never stall
   assign ready_o          = ~(ctrl_touch & sync_busy);
   wire logic wr_acc       = req_i & wr_i & ready_o;
   wire logic rd_acc       = req_i & ~wr_i;
   wire logic guard_ok     = ~access_guard_i;
   wire logic disabled     = ~enable_r & ~enable_eff_r;
   wire logic ctrl_wr      = wr_acc & sel_ctrl & be_i[0] & guard_ok;
   wire logic sw_req       = ctrl_wr & wdata_i[ext_pin_irq_pkg::CTRL_SOFT_RESET_BIT_BIT];
   wire logic keep         = ~sw_req;
   wire logic en_wr        = ctrl_wr & keep;
   wire logic sync_start   = sw_req | en_wr;
   wire logic nmi_ctrl_wr  = wr_acc & sel_ctrl & be_i[2] & guard_ok & disabled & keep;
   // the flag registers are never guarded
   wire logic nmi_clr      = wr_acc & sel_ctrl & be_i[3] & keep &
                             wdata_i[24 + ext_pin_irq_pkg::NMI_FLAG_BIT];
   wire logic evt_wr       = wr_acc & sel_evt & be_i[0] & guard_ok & disabled;
   wire logic clr_wr       = wr_acc & sel_clr & be_i[0] & guard_ok;
   wire logic set_wr       = wr_acc & sel_set & be_i[0] & guard_ok;
   wire logic flag_wr      = wr_acc & sel_flags & be_i[0];
   wire logic wake_wr      = wr_acc & sel_wake & be_i[0] & guard_ok & disabled;
   wire logic cfg_ok       = wr_acc & sel_cfg & guard_ok & disabled;
   wire logic soft_clr     = sync_done & soft_reset_bit_r;
   wire logic wipe         = srst_i | soft_clr;
   wire logic [7:0] hit_g  = hit & {8{enable_eff_r}};
   wire logic [7:0] flag_clr = flag_wr ? wdata_i[7:0] : 8'h00;
   // a pin event in the clearing cycle survives
   wire logic [7:0] flags_nxt = (flags_r & ~flag_clr) | hit_g;
   wire logic [7:0] irq_en_nxt = (irq_en_r & ~(clr_wr ? wdata_i[7:0] : 8'h00))
                                | (set_wr ? wdata_i[7:0] : 8'h00);
   wire logic nmi_flag_nxt = (nmi_flag_r & ~nmi_clr) | nmi_hit;

   // ==========================================================
   // helpers
   sync_track u_sync (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .start_i (sync_start),
      .busy_o  (sync_busy),
      .done_o  (sync_done)
   );

   genvar gi;
   generate
      for (gi = 0; gi < ext_pin_irq_pkg::NUM_PINS; gi++) begin : g_pin
         pin_detect u_det (
            .clk_i     (clk_i),
            .srst_i    (srst_i),
            .pin_i     (ext_irq_pin_i[gi]),
            .sense_i   (cfg_r[gi*ext_pin_irq_pkg::CFG_SLICE +: 3]),
            .filt_on_i (cfg_r[gi*ext_pin_irq_pkg::CFG_SLICE + ext_pin_irq_pkg::CFG_FILT]),
            .hit_o     (hit[gi]),
            .evt_o     (pin_evt[gi])
         );
      end
      for (gi = 0; gi < 4; gi++) begin : g_cfg
         always_ff @(posedge clk_i) begin
            if (wipe) begin
               cfg_r[gi*8 +: 8] <= ext_pin_irq_pkg::RST_BYTE;
            end else if (cfg_ok & be_i[gi]) begin
               cfg_r[gi*8 +: 8] <= wdata_i[gi*8 +: 8];
            end
         end
      end
   endgenerate

   // nmi detection ignores the enable bit
   pin_detect u_nmi (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .pin_i     (nmi_pin_i),
      .sense_i   (nmi_ctrl_r[2:0]),
      .filt_on_i (nmi_ctrl_r[3]),
      .hit_o     (nmi_hit),
      .evt_o     ()
   );

   // ==========================================================
   // control
   always_ff @(posedge clk_i) begin
      if (wipe) begin
         soft_reset_bit_r      <= 1'b0;
         enable_r     <= 1'b0;
         enable_eff_r <= 1'b0;
      end else begin
         if (sw_req) begin
            soft_reset_bit_r <= 1'b1;
         end
         if (en_wr) begin
            enable_r <= wdata_i[ext_pin_irq_pkg::CTRL_ENABLE_BIT];
         end
         if (sync_done) begin
            enable_eff_r <= enable_r;
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (wipe) begin
         nmi_ctrl_r <= 4'h0;
         nmi_flag_r <= 1'b0;
         evt_en_r   <= ext_pin_irq_pkg::RST_BYTE;
         irq_en_r   <= ext_pin_irq_pkg::RST_BYTE;
         flags_r    <= ext_pin_irq_pkg::RST_BYTE;
         wake_en_r  <= ext_pin_irq_pkg::RST_BYTE;
      end else begin
         if (nmi_ctrl_wr) begin
            nmi_ctrl_r <= wdata_i[19:16];
         end
         if (evt_wr) begin
            evt_en_r <= wdata_i[7:0];
         end
         if (wake_wr) begin
            wake_en_r <= wdata_i[7:0];
         end
         nmi_flag_r <= nmi_flag_nxt;
         irq_en_r   <= irq_en_nxt;
         flags_r    <= flags_nxt;
      end
   end

   // ==========================================================
   // outputs
   always_ff @(posedge clk_i) begin
      if (wipe) begin
         hit_evt_r <= ext_pin_irq_pkg::RST_BYTE;
         wake_r    <= 1'b0;
      end else begin
         hit_evt_r <= pin_evt & {8{enable_eff_r}} & evt_en_r;
         wake_r    <= sleep_i & (|(hit_g & wake_en_r));
      end
   end

   assign evt_o     = hit_evt_r;
   assign wake_o    = wake_r;
   assign irq_o     = |(flags_r & irq_en_r);
   assign nmi_irq_o = nmi_flag_r;

   // ==========================================================
   // read side
   // reserved bits are tied to zero in the assembled words
   wire logic [31:0] word0 = {7'h00, nmi_flag_r, 4'h0, nmi_ctrl_r,
                              sync_busy, 7'h00, 6'h00, enable_r, soft_reset_bit_r};
   wire logic [7:0] low8 = sel_evt ? evt_en_r :
                           (sel_clr | sel_set) ? irq_en_r :
                           sel_flags ? flags_r :
                           sel_wake ? wake_en_r : 8'h00;
   // unmapped words read as zero
   wire logic [31:0] rd_word = sel_ctrl ? word0 : sel_cfg ? cfg_r : {24'h000000, low8};
   wire logic [31:0] lane_mask = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}};

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rvalid_r <= 1'b0;
         rdata_r  <= ext_pin_irq_pkg::RST_WORD;
      end else begin
         rvalid_r <= rd_acc;
         if (rd_acc) begin
            rdata_r <= rd_word & lane_mask;
         end
      end
   end

   assign rvalid_o = rvalid_r;
   assign rdata_o  = rdata_r;

   // ==========================================================
   // checks
   property p_evt_needs_en;
      @(posedge clk_i) disable iff (srst_i)
      (evt_o != 8'h00) |-> ((evt_o & $past(evt_en_r)) == evt_o);
   endproperty
   a_evt_needs_en: assert property (p_evt_needs_en) else $error("event without enable");

   property p_evt_en_wr;
      @(posedge clk_i) disable iff (srst_i)
      (evt_wr && !soft_clr) |=> (evt_en_r == $past(wdata_i[7:0]));
   endproperty
   a_evt_en_wr: assert property (p_evt_en_wr) else $error("event enable not written");

   property p_wake;
      @(posedge clk_i) disable iff (srst_i)
      wake_o |-> ($past(sleep_i) && ($past(hit_g & wake_en_r) != 8'h00));
   endproperty
   a_wake: assert property (p_wake) else $error("wake without enabled match");

   property p_busy_window;
      @(posedge clk_i) disable iff (srst_i)
      sync_start |=> sync_busy ##[1:4] !sync_busy;
   endproperty
   a_busy_window: assert property (p_busy_window) else $error("sync_pending timing");

   property p_stall_bounded;
      @(posedge clk_i) disable iff (srst_i)
      !ready_o |-> (sync_busy && ctrl_touch) ##[1:5] ready_o;
   endproperty
   a_stall_bounded: assert property (p_stall_bounded) else $error("bad bus stall");

   property p_enable_late;
      @(posedge clk_i) disable iff (srst_i)
      (en_wr && (wdata_i[1] != enable_eff_r)) |=> (enable_eff_r != enable_r) [*2];
   endproperty
   a_enable_late: assert property (p_enable_late) else $error("enable too early");

   property p_soft_reset;
      @(posedge clk_i) disable iff (srst_i)
      soft_clr |=> (!soft_reset_bit_r && !sync_busy && !enable_eff_r && flags_r == 8'h00);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset late");

   property p_discard;
      @(posedge clk_i) disable iff (srst_i)
      sw_req |=> (enable_r == $past(enable_r) && nmi_ctrl_r == $past(nmi_ctrl_r));
   endproperty
   a_discard: assert property (p_discard) else $error("soft reset write kept bits");

   property p_guard;
      @(posedge clk_i) disable iff (srst_i)
      (access_guard_i && !soft_clr) |=>
         (wake_en_r == $past(wake_en_r) && irq_en_r == $past(irq_en_r));
   endproperty
   a_guard: assert property (p_guard) else $error("guarded write accepted");

   property p_enprot;
      @(posedge clk_i) disable iff (srst_i)
      ((enable_r || enable_eff_r) && !soft_clr) |=> (cfg_r == $past(cfg_r));
   endproperty
   a_enprot: assert property (p_enprot) else $error("config written while enabled");

   property p_set_wins;
      @(posedge clk_i) disable iff (srst_i)
      // any pin, so the level pins of the bench reach it during flag clears
      ((hit_g != 8'h00) && !soft_clr) |=>
         (((flags_r & $past(hit_g)) == $past(hit_g)) &&
          (irq_o || ((irq_en_r & $past(hit_g)) == 8'h00)));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag event lost");

endmodule

// ===== pin_partner.sv
// pin partner: drives the external pins, counts event cycles per pin
// assumes the unit's clock; pins change just after an edge
`timescale 1ns/10ps

module pin_partner (
   // clock
   input  wire logic       clk_i,
   // pin command and event watch
   input  wire logic [7:0] want_i,
   input  wire logic [7:0] evt_i,
   // pins and counts
   output logic [7:0]      pin_o,
   output int              cnt_o [8]
);
   // ==========================================
   // pins and event counts
   // counting high cycles; a held level gives one event cycle at its onset, so it counts once
   always @(posedge clk_i) begin
      pin_o <= want_i;
      for (int i = 0; i < 8; i++) begin
         cnt_o[i] <= cnt_o[i] + int'(evt_i[i]);
      end
   end
endmodule

// ===== tb.sv
// bench for the pin interrupt unit: bus tasks, pin model, checks
// assumes one clock shared by unit and pin partner
`timescale 1ns/10ps

module tb;
   logic        clk_i   = 1'b0;
   logic        srst_i  = 1'b1;
   logic        req_i   = 1'b0;
   logic        wr_i    = 1'b0;
   logic [7:0]  addr_i  = 8'h00;
   logic [3:0]  be_i    = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic        guard   = 1'b0;
   logic        sleep   = 1'b0;
   logic        nmi     = 1'b0;
   logic        nmi_irq_o;
   logic [7:0]  want    = 8'h00;
   logic [7:0]  p       = 8'h00;
   logic [15:0] seed    = 16'h5625;
   logic [7:0]  pins;
   logic [7:0]  mflag;
   logic [7:0]  evt_o;
   logic        ready_o;
   logic        rvalid_o;
   logic        irq_o;
   logic        wake_o;
   logic [31:0] rdata_o;
   logic [31:0] rd;
   int          cnt [8];
   int          evexp [8];
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          stalls = 0;

   always #5 clk_i = ~clk_i;

   ext_pin_irq_unit dut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i), .wr_i(wr_i),
      .addr_i(addr_i), .be_i(be_i), .wdata_i(wdata_i), .ready_o(ready_o),
      .rvalid_o(rvalid_o), .rdata_o(rdata_o), .access_guard_i(guard), .sleep_i(sleep),
      .ext_irq_pin_i(pins), .nmi_pin_i(nmi), .irq_o(irq_o), .nmi_irq_o(nmi_irq_o),
      .evt_o(evt_o), .wake_o(wake_o));
   pin_partner partner (.clk_i(clk_i), .want_i(want), .evt_i(evt_o), .pin_o(pins),
      .cnt_o(cnt));

   // ==========================================
   // helpers
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // request held until the edge that sees ready high
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      int k;
      k = 0;
      req_i   <= 1'b1;
      wr_i    <= w;
      addr_i  <= a;
      be_i    <= b;
      wdata_i <= d;
      @(posedge clk_i);
      while (ready_o !== 1'b1) begin
         stalls++;
         k++;
         if (k > 50) begin
            n_mismatch++;
            complete_run();
         end
         @(posedge clk_i);
      end
      req_i <= 1'b0;
      #1;
      if (w === 1'b0) begin
         chk("rvalid", {31'h0, rvalid_o}, 32'h1);
         rd = rdata_o;
      end
      @(posedge clk_i);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [3:0] b, input logic [31:0] e);
      bus(1'b0, a, b, 32'h0);
      chk($sformatf("read %h", a), rd, e);
   endtask

   task automatic idle();
      int k;
      k = 0;
      rd = 32'h8000;
      while (rd[15] !== 1'b0 && k < 20) begin
         bus(1'b0, ext_pin_irq_pkg::OFS_STATUS, 4'h2, 32'h0);
         k++;
      end
      chk("sync done", {31'h0, rd[15]}, 32'h0);
      if (rd[15] !== 1'b0) complete_run();
   endtask

   // pin x uses sense code x; pin 1 filtered; pin 5 event off
   task automatic step(input logic [7:0] n);
      logic e;
      logic s;
      want <= n;
      repeat (12) @(posedge clk_i);
      for (int x = 0; x < 8; x++) begin
         e = (x == 1 && !p[x] && n[x]) || (x == 2 && p[x] && !n[x]) || (x == 3 && p[x] != n[x])
            || (x == 4 && !p[x] && n[x]) || (x == 5 && p[x] && !n[x]);
         s = e || (x == 4 && n[x]) || (x == 5 && !n[x]);
         mflag[x] = mflag[x] | s;
         if (e && x != 5) evexp[x]++;
      end
      p = n;
      chk("wake", {31'h0, wake_o}, {31'h0, n[4]});
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a < 32; a += 4) rchk(8'(a), 4'hf, 32'h0);
      $display("test reset values done");
      bus(1'b1, ext_pin_irq_pkg::OFS_PIN_CFG, 4'h3, 32'h0000_3290);
      bus(1'b1, ext_pin_irq_pkg::OFS_PIN_CFG, 4'hc, 32'h7654_0000);
      rchk(ext_pin_irq_pkg::OFS_PIN_CFG, 4'hf, 32'h7654_3290);
      bus(1'b1, ext_pin_irq_pkg::OFS_EVT_EN, 4'h1, 32'hdf);
      bus(1'b1, ext_pin_irq_pkg::OFS_IRQ_SET, 4'h1, 32'h3c);
      bus(1'b1, ext_pin_irq_pkg::OFS_IRQ_CLR, 4'h1, 32'h0c);
      // wake bit only after its interrupt is enabled
      bus(1'b1, ext_pin_irq_pkg::OFS_WAKE, 4'h1, 32'h10);
      rchk(ext_pin_irq_pkg::OFS_IRQ_SET, 4'h1, 32'h30);
      bus(1'b1, ext_pin_irq_pkg::OFS_CTRL, 4'h1, 32'h02);
      rchk(ext_pin_irq_pkg::OFS_CTRL, 4'h3, 32'h8002);
      idle();
      bus(1'b1, ext_pin_irq_pkg::OFS_EVT_EN, 4'h1, 32'h00);
      rchk(ext_pin_irq_pkg::OFS_EVT_EN, 4'hf, 32'hdf);
      bus(1'b1, ext_pin_irq_pkg::OFS_FLAGS, 4'h1, 32'hff);
      mflag = 8'h20;
      sleep <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         seed = lfsr_next(seed);
         step(seed[7:0]);
         rchk(ext_pin_irq_pkg::OFS_FLAGS, 4'h1, {24'h0, mflag});
         chk("irq", {31'h0, irq_o}, {31'h0, |(mflag & 8'h30)});
         bus(1'b1, ext_pin_irq_pkg::OFS_FLAGS, 4'h1, 32'hff);
         mflag = (p & 8'h10) | (~p & 8'h20);
      end
      step(8'h00);
      bus(1'b1, ext_pin_irq_pkg::OFS_FLAGS, 4'h1, 32'hff);
      want <= 8'h02;
      @(posedge clk_i);
      want <= 8'h00;
      repeat (12) @(posedge clk_i);
      rchk(ext_pin_irq_pkg::OFS_FLAGS, 4'h1, 32'h20);
      for (int x = 0; x < 8; x++) chk("events", 32'(cnt[x]), 32'(evexp[x]));
      $display("test pins done");
      guard <= 1'b1;
      bus(1'b1, ext_pin_irq_pkg::OFS_IRQ_SET, 4'h1, 32'hff);
      rchk(ext_pin_irq_pkg::OFS_IRQ_SET, 4'h1, 32'h30);
      guard <= 1'b0;
      stalls = 0;
      bus(1'b1, ext_pin_irq_pkg::OFS_CTRL, 4'h1, 32'h02);
      bus(1'b1, ext_pin_irq_pkg::OFS_CTRL, 4'hf, 32'h0004_0003);
      chk("stall", {31'h0, stalls > 0}, 32'h1);
      bus(1'b0, ext_pin_irq_pkg::OFS_CTRL, 4'h7, 32'h0);
      chk("soft reset", rd & 32'hffff_fffd, 32'h0000_8001);
      idle();
      rchk(ext_pin_irq_pkg::OFS_CTRL, 4'hf, 32'h0);
      rchk(ext_pin_irq_pkg::OFS_EVT_EN, 4'hf, 32'h0);
      rchk(ext_pin_irq_pkg::OFS_PIN_CFG, 4'hf, 32'h0);
      // nmi: high-level sense through its own byte lane, flag clear not guarded
      bus(1'b1, ext_pin_irq_pkg::OFS_NMI_CTRL, 4'h4, 32'h0004_0000);
      nmi <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk("nmi irq", {31'h0, nmi_irq_o}, 32'h1);
      rchk(ext_pin_irq_pkg::OFS_NMI_FLAG, 4'h8, 32'h0100_0000);
      nmi <= 1'b0;
      guard <= 1'b1;
      repeat (8) @(posedge clk_i);
      bus(1'b1, ext_pin_irq_pkg::OFS_NMI_FLAG, 4'h8, 32'h0100_0000);
      guard <= 1'b0;
      chk("nmi clear", {31'h0, nmi_irq_o}, 32'h0);
      // reserved control bits are written as zero
      bus(1'b1, ext_pin_irq_pkg::OFS_CTRL, 4'h1, 32'h02);
      idle();
      rchk(ext_pin_irq_pkg::OFS_CTRL, 4'h1, 32'h02);
      $display("test control done");
      complete_run();
   end
endmodule
